// file: rtl/rtam_pkg.sv
// package for the refresh timer and dram address multiplexer block
package rtam_pkg;
  // apb byte addresses of the registers
  localparam logic [7:0] RTAM_OFF_CSR = 8'h00;
  localparam logic [7:0] RTAM_OFF_COUNT = 8'h04;
  localparam logic [7:0] RTAM_OFF_COMPARE = 8'h08;
  localparam logic [7:0] RTAM_OFF_DRAM_CTRL = 8'h0C;
  // field positions in refresh_timer_ctrl_status
  localparam int RTAM_CSR_FLAG_BIT = 7;
  localparam int RTAM_CSR_IEN_BIT = 6;
  localparam int RTAM_CSR_CKS_LSB = 3;
  // field positions in dram_control_b
  localparam int RTAM_DCB_COLW_LSB = 0;
  localparam int RTAM_DCB_AREA_LSB = 2;
  // reset values
  localparam logic [2:0] RTAM_CKS_RESET = 3'h0;
  localparam logic [2:0] RTAM_CSR_RSVD_ONES = 3'h7;
  localparam logic [7:0] RTAM_COUNT_RESET = 8'h00;
  localparam logic [7:0] RTAM_COMPARE_RESET = 8'hFF;
  localparam logic [5:0] RTAM_DCB_RESET = 6'h00;
  // prescaler width, enough for the slowest divide of 4096
  localparam int RTAM_PRE_W = 12;
  // column width select encodings
  localparam logic [1:0] RTAM_COLW_8 = 2'h0;
  localparam logic [1:0] RTAM_COLW_9 = 2'h1;
  localparam logic [1:0] RTAM_COLW_10 = 2'h2;
  // highest logical address bit that is multiplexed in the row phase
  localparam int RTAM_ROW_TOP = 20;
  // highest address pin that ever carries a shifted row bit
  localparam int RTAM_ROW_PIN_TOP = 12;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rtam_apb_req_type;

  // one external bus cycle request from the bus controller
  typedef struct packed {
    logic [23:0] logical_addr;
    logic row_phase;
    logic two_state16;
    logic byte_access;
  } rtam_bus_req_type;
endpackage : rtam_pkg

// file: rtl/rtam_refresh_mux.sv
// refresh interval timer with compare flag plus dram row/column address multiplexer
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps

// How it works
// - count equal to compare sets match flag
// - reset, standby, or read-one-then-write-zero clears flag
// - writing one to match flag does nothing
// - interrupt requested when flag and enable set
// - any dram area forces enable to zero
// - clock select picks halt or divided clock
// - counter steps up once select is nonzero
// - low three status bits read one always
// - two-state 16-bit byte lane by address parity
// - no wait states in two-state 16-bit areas
// - row phase shifts address by column width
module rtam_refresh_mux (
  input wire logic clock,
  input wire logic arst_n,
  input wire rtam_pkg::rtam_apb_req_type apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic standby,
  input wire rtam_pkg::rtam_bus_req_type bus_req,
  input wire logic wait_pin,
  output logic [23:0] addr_pins,
  output logic lane_hi_en,
  output logic lane_lo_en,
  output logic insert_wait,
  output logic match_interrupt
);

  // selects the prescaler tick for a clock select code
  function automatic logic div_tick(input logic [2:0] sel,
                                    input logic [rtam_pkg::RTAM_PRE_W-1:0] pre);
    logic t;
    t = 1'b0;
    case (sel)
      3'h1: t = &pre[0:0];
      3'h2: t = &pre[2:0];
      3'h3: t = &pre[4:0];
      3'h4: t = &pre[6:0];
      3'h5: t = &pre[8:0];
      3'h6: t = &pre[10:0];
      3'h7: t = &pre[11:0];
      default: t = 1'b0;
    endcase
    return t;
  endfunction : div_tick

  // register state
  logic flag_r; // match flag
  logic flag_nxt;
  logic ien_r; // match interrupt enable
  logic ien_nxt;
  logic [2:0] cks_r; // refresh clock select
  logic [7:0] count_r; // refresh count
  logic [7:0] count_nxt;
  logic [7:0] compare_r; // refresh compare value
  logic [5:0] dcb_r; // dram_control_b: area enables and column width
  logic armed_r; // flag was read as one since the last csr write
  logic armed_nxt;
  logic [rtam_pkg::RTAM_PRE_W-1:0] pre_r; // free running system clock divider
  logic [31:0] prdata_r;
  logic [23:0] addr_r;
  logic hi_r;
  logic lo_r;
  logic wait_s1_r; // wait pin synchroniser stages
  logic wait_s2_r;
  logic wait_s3_r;
  logic wait_lvl_r; // filtered wait level

  // apb decode
  wire setup_ph = apb_req.psel & ~apb_req.penable;
  wire access_ph = apb_req.psel & apb_req.penable;
  wire wr_acc = access_ph & apb_req.pwrite;
  wire rd_acc = access_ph & ~apb_req.pwrite;
  wire hit_csr = apb_req.paddr == rtam_pkg::RTAM_OFF_CSR;
  wire hit_count = apb_req.paddr == rtam_pkg::RTAM_OFF_COUNT;
  wire hit_compare = apb_req.paddr == rtam_pkg::RTAM_OFF_COMPARE;
  wire hit_dcb = apb_req.paddr == rtam_pkg::RTAM_OFF_DRAM_CTRL;
  wire hit_any = hit_csr | hit_count | hit_compare | hit_dcb;
  wire wr_csr = wr_acc & hit_csr;
  wire wr_count = wr_acc & hit_count;
  wire [7:0] wbyte = apb_req.pwdata[7:0];

  // timer decode
  wire [2:0] cks_new = wbyte[rtam_pkg::RTAM_CSR_CKS_LSB +: 3];
  wire tick = div_tick(cks_r, pre_r);
  wire [7:0] count_inc = count_r + 8'h01;
  wire set_evt = tick & ~wr_count & (count_inc == compare_r);
  wire sw_clear = wr_csr & armed_r & ~wbyte[rtam_pkg::RTAM_CSR_FLAG_BIT];
  wire dram_any = |dcb_r[rtam_pkg::RTAM_DCB_AREA_LSB +: 4];
  wire [7:0] csr_view = {flag_r, ien_r, cks_r, rtam_pkg::RTAM_CSR_RSVD_ONES};
  wire [1:0] colw = dcb_r[rtam_pkg::RTAM_DCB_COLW_LSB +: 2];

  // read mux, unmapped addresses read zero
  wire [7:0] rd_byte = hit_csr ? csr_view :
                       hit_count ? count_r :
                       hit_compare ? compare_r :
                       hit_dcb ? {2'h0, dcb_r} : 8'h00;

  // flag: hardware set beats the software clear, standby beats both
  always_comb
  begin
    flag_nxt = flag_r;
    if (sw_clear)
      flag_nxt = 1'b0;
    if (set_evt)
      flag_nxt = 1'b1;
    if (standby)
      flag_nxt = 1'b0;
  end

  // a one written to the flag is simply not a clear; nothing sets it from the bus
  // arming looks at the flag value the read returned, not the live flag, so a flag that
  // sets between the setup and access edges is never cleared before software saw it
  assign armed_nxt = (rd_acc & hit_csr & prdata_r[rtam_pkg::RTAM_CSR_FLAG_BIT]) ? 1'b1 :
                     (wr_csr ? 1'b0 : armed_r);

  // enable only sticks while no area is dram
  assign ien_nxt = dram_any ? 1'b0 :
                   (wr_csr ? wbyte[rtam_pkg::RTAM_CSR_IEN_BIT] : ien_r);

  // software write to the count wins over a tick in the same cycle
  assign count_nxt = wr_count ? wbyte : (tick ? count_inc : count_r);

  // control and timer registers
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flag_r <= 1'b0;
      ien_r <= 1'b0;
      cks_r <= rtam_pkg::RTAM_CKS_RESET;
      armed_r <= 1'b0;
    end
    else
    begin
      flag_r <= flag_nxt;
      ien_r <= ien_nxt;
      armed_r <= armed_nxt;
      if (wr_csr)
        cks_r <= cks_new;
    end
  end

  // counter, compare, dram control; the compare resets high so an idle timer stays quiet
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_r <= rtam_pkg::RTAM_COUNT_RESET;
      compare_r <= rtam_pkg::RTAM_COMPARE_RESET;
      dcb_r <= rtam_pkg::RTAM_DCB_RESET;
      pre_r <= '0;
    end
    else
    begin
      count_r <= count_nxt;
      pre_r <= pre_r + 1'b1;
      if (wr_acc & hit_compare)
        compare_r <= wbyte;
      if (wr_acc & hit_dcb)
        dcb_r <= wbyte[5:0];
    end
  end

  // read data is latched in the setup cycle so the access phase answers at once
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      prdata_r <= 32'h0000_0000;
    else if (setup_ph & ~apb_req.pwrite)
      prdata_r <= {24'h00_0000, rd_byte};
  end

  assign prdata = prdata_r;
  assign pready = 1'b1; // zero wait slave
  assign pslverr = access_ph & ~hit_any;
  assign match_interrupt = flag_r & ien_r;

  // row address bits: each low pin takes the bit one column width higher while that bit is at most bit 20
  logic [23:0] row_addr;
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi = gi + 1)
    begin : g_row
      if (gi > rtam_pkg::RTAM_ROW_PIN_TOP)
      begin : g_keep
        assign row_addr[gi] = bus_req.logical_addr[gi];
      end
      else
      begin : g_shift
        wire [4:0] idx8 = 5'(gi + 8);
        wire [4:0] idx9 = 5'(gi + 9);
        wire [4:0] idx10 = 5'(gi + 10);
        assign row_addr[gi] =
          (colw == rtam_pkg::RTAM_COLW_8) ?
            ((gi + 8 <= rtam_pkg::RTAM_ROW_TOP) ? bus_req.logical_addr[idx8]
                                                : bus_req.logical_addr[gi]) :
          (colw == rtam_pkg::RTAM_COLW_9) ?
            ((gi + 9 <= rtam_pkg::RTAM_ROW_TOP) ? bus_req.logical_addr[idx9]
                                                : bus_req.logical_addr[gi]) :
          (colw == rtam_pkg::RTAM_COLW_10) ?
            ((gi + 10 <= rtam_pkg::RTAM_ROW_TOP) ? bus_req.logical_addr[idx10]
                                                 : bus_req.logical_addr[gi]) :
            bus_req.logical_addr[gi];
      end
    end
  endgenerate

  // column phase or the unsupported fourth code pass the address through
  wire [23:0] addr_sel = bus_req.row_phase ? row_addr : bus_req.logical_addr;

  // byte lanes: even bytes high, odd bytes low, words on both
  wire hi_sel = ~bus_req.byte_access | ~bus_req.logical_addr[0];
  wire lo_sel = ~bus_req.byte_access | bus_req.logical_addr[0];

  // pin driving registers
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      addr_r <= 24'h00_0000;
      hi_r <= 1'b0;
      lo_r <= 1'b0;
    end
    else
    begin
      addr_r <= addr_sel;
      hi_r <= hi_sel;
      lo_r <= lo_sel;
    end
  end

  assign addr_pins = addr_r;
  assign lane_hi_en = hi_r;
  assign lane_lo_en = lo_r;

  // wait pin: three stages, the level moves only when stages two and three agree
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wait_s1_r <= 1'b0;
      wait_s2_r <= 1'b0;
      wait_s3_r <= 1'b0;
      wait_lvl_r <= 1'b0;
    end
    else
    begin
      wait_s1_r <= wait_pin;
      wait_s2_r <= wait_s1_r;
      wait_s3_r <= wait_s2_r;
      if (wait_s2_r == wait_s3_r)
        wait_lvl_r <= wait_s3_r;
    end
  end

  // fast areas have a fixed two-state cycle, so the pin is ignored there
  assign insert_wait = wait_lvl_r & ~bus_req.two_state16;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence s_read_one;
    rd_acc && hit_csr && prdata_r[rtam_pkg::RTAM_CSR_FLAG_BIT];
  endsequence

  sequence s_write_zero;
    wr_csr && !wbyte[rtam_pkg::RTAM_CSR_FLAG_BIT] && !set_evt && !standby;
  endsequence

  a_flag_set_match: assert property (
    (tick && !wr_count && count_inc == compare_r && !standby) |=> flag_r)
    else $error("match flag not set on compare match");

  // the clearing write is the very next transfer, two or three cycles after the read
  a_flag_read_clear: assert property (
    s_read_one ##[2:3] s_write_zero |=> !flag_r)
    else $error("match flag not cleared by read one then write zero");

  a_standby_clear: assert property (
    standby |=> !flag_r)
    else $error("match flag survived standby");

  a_write_one_noop: assert property (
    (!flag_r && wr_csr && !set_evt) |=> !flag_r)
    else $error("bus write set the match flag");

  a_irq_follows: assert property (
    $rose(match_interrupt) |-> ($past(set_evt) || $past(wr_csr)) && ien_r)
    else $error("interrupt rose without flag and enable cause");

  a_ien_write: assert property (
    (wr_csr && !dram_any) |=> ien_r == $past(wbyte[rtam_pkg::RTAM_CSR_IEN_BIT]))
    else $error("interrupt enable write lost");

  a_dram_no_ien: assert property (
    dram_any |=> !ien_r && !match_interrupt)
    else $error("enable held while dram area configured");

  a_halt_count: assert property (
    (cks_r == 3'h0 && !wr_count) |=> count_r == $past(count_r))
    else $error("counter moved while halted");

  a_count_write: assert property (
    wr_count |=> count_r == $past(wbyte))
    else $error("software count write lost");

  // three quiet cycles so that both counted edges are free of bus writes
  a_div2_rate: assert property (
    (cks_r == 3'h1 && !wr_acc)[*3] |-> count_r != $past(count_r, 2))
    else $error("counter did not step at divide by two");

  a_rsvd_ones: assert property (
    (setup_ph && !apb_req.pwrite && hit_csr) |=> prdata[2:0] == 3'h7)
    else $error("reserved status bits not read as one");

  a_lane_split: assert property (
    (bus_req.two_state16 && bus_req.byte_access)
      |=> lane_hi_en == !$past(bus_req.logical_addr[0]) && lane_lo_en != lane_hi_en)
    else $error("byte lane wrong for address parity");

  a_no_wait: assert property (
    bus_req.two_state16 |-> !insert_wait)
    else $error("wait inserted in two-state area");

  a_row_8bit: assert property (
    (bus_req.row_phase && colw == rtam_pkg::RTAM_COLW_8)
      |=> addr_pins == {$past(bus_req.logical_addr[23:13]), $past(bus_req.logical_addr[20:8])})
    else $error("row address wrong for eight column bits");

  a_row_9bit: assert property (
    (bus_req.row_phase && colw == rtam_pkg::RTAM_COLW_9)
      |=> addr_pins == {$past(bus_req.logical_addr[23:12]), $past(bus_req.logical_addr[20:9])})
    else $error("row address wrong for nine column bits");

  a_row_10bit: assert property (
    (bus_req.row_phase && colw == rtam_pkg::RTAM_COLW_10)
      |=> addr_pins == {$past(bus_req.logical_addr[23:11]), $past(bus_req.logical_addr[20:10])})
    else $error("row address wrong for ten column bits");

  a_col_pass: assert property (
    !bus_req.row_phase |=> addr_pins == $past(bus_req.logical_addr))
    else $error("column address not passed through");

endmodule : rtam_refresh_mux

// file: verif/rtam_mem_model.sv
// external memory model that answers bus cycles promptly or with wait requests
`timescale 1ns/10ps
module rtam_mem_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic lane_hi_en,
  input wire logic lane_lo_en,
  input wire logic slow,
  output logic wait_pin
);
  // a slow part asks for wait while a data lane is in use
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      wait_pin <= 1'b0;
    else
      wait_pin <= slow && (lane_hi_en || lane_lo_en);
  end
endmodule : rtam_mem_model

// file: verif/rtam_refresh_mux_tb.sv
// self-checking bench for the refresh timer and dram address multiplexer
`timescale 1ns/10ps
module rtam_refresh_mux_tb;
  logic clock = 1'b0; // system clock
  logic arst_n = 1'b0; // reset, active low
  rtam_pkg::rtam_apb_req_type apb_req = '0; // apb master side
  rtam_pkg::rtam_bus_req_type bus_req = '0; // bus controller side
  logic standby = 1'b0; // standby level
  logic slow = 1'b0; // memory asks for wait
  logic [31:0] prdata;
  logic pready, pslverr, wait_pin, lane_hi_en, lane_lo_en, insert_wait, match_interrupt;
  logic [23:0] addr_pins;
  logic [31:0] rd; // last read word
  int fails = 0;
  int total_checks = 0;
  // divide ratio per clock select code, 0 means halted
  int dv[8] = '{0, 2, 8, 32, 128, 512, 2048, 4096};
  always #25 clock = ~clock;
  rtam_refresh_mux dut_u (.clock(clock), .arst_n(arst_n), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .standby(standby), .bus_req(bus_req),
    .wait_pin(wait_pin), .addr_pins(addr_pins), .lane_hi_en(lane_hi_en),
    .lane_lo_en(lane_lo_en), .insert_wait(insert_wait), .match_interrupt(match_interrupt));
  rtam_mem_model mem_u (.clock(clock), .arst_n(arst_n), .lane_hi_en(lane_hi_en),
    .lane_lo_en(lane_lo_en), .slow(slow), .wait_pin(wait_pin));

  // final counts and verdict, the only exit
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  // exact value compare
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // range compare, for counts whose phase against the prescaler is free
  task automatic chk_rng(input string what, input int lo, input int hi, input logic [31:0] got);
    logic ok;
    ok = (got >= lo) && (got <= hi);
    total_checks++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("unexpected %s: expected %0d..%0d seen %h", what, lo, hi, got);
    end
  endtask : chk_rng

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    apb_req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fails++;
      summarize();
    end
    rd = prdata;
    chk("slave error", {31'h0, a > 8'h0C}, {31'h0, pslverr});
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  // bounded wait for the interrupt to reach a level
  task automatic wait_irq(input int bound);
    int n;
    n = 0;
    while (match_interrupt !== 1'b1 && n < bound)
    begin
      @(posedge clock);
      n++;
    end
    chk("interrupt raised", 1, match_interrupt);
    if (match_interrupt !== 1'b1)
      summarize();
  endtask : wait_irq

  // one bus request, result looked at one cycle later
  task automatic bus(input logic [23:0] a, input logic r, input logic t, input logic b);
    @(posedge clock);
    bus_req <= '{logical_addr:a, row_phase:r, two_state16:t, byte_access:b};
    @(posedge clock);
    #1;
  endtask : bus

  // expected pins: row phase moves the bits from the column width up to 20 down
  function automatic logic [23:0] mux_exp(input logic [23:0] a, input int c, input logic r);
    logic [23:0] e;
    e = a;
    if (r && c < 3)
      for (int i = 0; i <= 12 - c; i++)
        e[i] = a[i + 8 + c];
    return e;
  endfunction : mux_exp

  // reset values and an unmapped address
  task automatic t_reset;
    apb(0, rtam_pkg::RTAM_OFF_CSR, 0);
    chk("csr", 32'h07, rd);
    apb(0, rtam_pkg::RTAM_OFF_COUNT, 0);
    chk("count", 32'h00, rd);
    apb(0, 8'h10, 0);
    chk("unmapped", 32'h00, rd);
    $display("reset test done");
  endtask : t_reset

  // writing ones to the flag and reserved bits changes neither
  task automatic t_fields;
    apb(1, rtam_pkg::RTAM_OFF_CSR, 32'hFF);
    apb(0, rtam_pkg::RTAM_OFF_CSR, 0);
    chk("csr ones", 32'h7F, rd);
    $display("field test done");
  endtask : t_fields

  // every clock select code, counting for four periods
  task automatic t_clock;
    for (int k = 0; k < 8; k++)
    begin
      apb(1, rtam_pkg::RTAM_OFF_CSR, k << 3);
      apb(1, rtam_pkg::RTAM_OFF_COUNT, 0);
      repeat (k ? 4 * dv[k] : 16) @(posedge clock);
      apb(0, rtam_pkg::RTAM_OFF_COUNT, 0);
      chk_rng("count steps", k ? 4 : 0, k ? 5 : 0, rd);
      apb(0, rtam_pkg::RTAM_OFF_CSR, 0);
      chk("csr select", (k << 3) | 7, rd);
    end
    $display("clock select test done");
  endtask : t_clock

  // match, read-then-clear, blind write, standby clear, dram lock of the enable
  task automatic t_flag;
    apb(1, rtam_pkg::RTAM_OFF_COMPARE, 3);
    apb(1, rtam_pkg::RTAM_OFF_COUNT, 0);
    apb(1, rtam_pkg::RTAM_OFF_CSR, 32'h48);
    wait_irq(100);
    apb(0, rtam_pkg::RTAM_OFF_CSR, 0);
    chk("csr match", 32'hCF, rd);
    apb(1, rtam_pkg::RTAM_OFF_CSR, 32'h48);
    #1;
    chk("cleared irq", 0, match_interrupt);
    wait_irq(600);
    apb(1, rtam_pkg::RTAM_OFF_CSR, 32'h08);
    #1;
    chk("masked irq", 0, match_interrupt);
    apb(0, rtam_pkg::RTAM_OFF_CSR, 0);
    chk("unread flag", 32'h8F, rd);
    @(posedge clock);
    standby <= 1'b1;
    @(posedge clock);
    standby <= 1'b0;
    apb(0, rtam_pkg::RTAM_OFF_CSR, 0);
    chk("standby flag", 32'h0F, rd);
    apb(1, rtam_pkg::RTAM_OFF_CSR, 32'h40);
    apb(1, rtam_pkg::RTAM_OFF_DRAM_CTRL, 32'h04);
    apb(0, rtam_pkg::RTAM_OFF_CSR, 0);
    chk("csr dram", 32'h07, rd);
    $display("flag test done");
  endtask : t_flag

  // row and column addresses for every column width code
  task automatic t_mux;
    for (int c = 0; c < 4; c++)
    begin
      apb(1, rtam_pkg::RTAM_OFF_DRAM_CTRL, c);
      for (int r = 0; r < 2; r++)
      begin
        bus(24'hA5C3E7 ^ (c << 9), r, 0, 0);
        chk("pins", mux_exp(24'hA5C3E7 ^ (c << 9), c, r), addr_pins);
      end
    end
    $display("mux test done");
  endtask : t_mux

  // byte lanes and wait suppression in two-state areas
  task automatic t_lanes;
    bus(24'h000100, 0, 1, 1);
    chk("lanes even", 2, {lane_hi_en, lane_lo_en});
    bus(24'h000101, 0, 1, 1);
    chk("lanes odd", 1, {lane_hi_en, lane_lo_en});
    slow <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      bus(24'h000100, 0, 1, 0);
      chk("no wait", 0, insert_wait);
    end
    for (int i = 0; i < 8; i++)
      bus(24'h000100, 0, 0, 0);
    chk("wait path", 1, insert_wait);
    slow <= 1'b0;
    $display("lane test done");
  endtask : t_lanes

  // main sequence
  initial
  begin
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    t_reset();
    t_fields();
    t_clock();
    t_flag();
    t_mux();
    t_lanes();
    summarize();
  end
endmodule : rtam_refresh_mux_tb
